// ---- core/cmts_pkg.sv ----
// Constants and types shared by the coprocessor memory transfer sequencer.
// Assumes a single 50 MHz core clock and a synchronous active-low reset.
// How it works
// - Load: core issues addresses and read requests.
// - Store: core issues addresses and write requests.
// - Interrupt may abandon a busy-waiting transfer.
// - Transfers only in full-width instruction state.
// - Single word LAST at decode: one cycle.
// - WAIT gives idle cycles; access follows GO/LAST.
// - First access nonsequential, later ones sequential.
// - Fetch held idle; sequential only last cycle.
// - Store word follows its address by one cycle.
// - Condition pass one, cancel-after-issue zero.
package cmts_pkg;

    typedef enum logic [1:0] {
        HS_NO_COPROC_CODE,
        HS_WAIT,
        HS_GO,
        HS_LAST
    } cmts_hs_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_XFER,
        ST_DONE
    } cmts_state_t;

    localparam int          ADDR_W      = 32;
    localparam int          DATA_W      = 32;
    localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
    localparam logic [31:0] FETCH_AHEAD = 32'h0000_000c;
    localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
    localparam int          BUF_DEPTH   = 2;

endpackage

// ---- core/cmts_sequencer.sv ----
// Coprocessor load/store transfer sequencer of the core's memory stage.
// Assumes the decoder presents one instruction at a time with a start address.
`timescale 1ns/1ps
`default_nettype none
module cmts_sequencer (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        instrValid,
    input  wire logic                        coproc_load_op,
    input  wire logic                        coproc_store_op,
    input  wire logic                        fullWidthState,
    input  wire logic [cmts_pkg::ADDR_W-1:0] startAddr,
    input  wire logic [cmts_pkg::ADDR_W-1:0] pcAddr,
    input  wire logic                        irqPending,
    output logic                             instrAccept,
    output logic                             xferDone,
    output logic                             xferAbandoned,
    output logic                             noCoproc,
    input  wire cmts_pkg::cmts_hs_t          decode_stage_handshake,
    input  wire cmts_pkg::cmts_hs_t          execute_stage_handshake,
    output logic                             condPass,
    output logic                             cancel_after_issue,
    output logic [cmts_pkg::ADDR_W-1:0]      fetch_addr_bus,
    output logic                             fetch_request_n,
    output logic                             fetch_sequential,
    output logic [cmts_pkg::ADDR_W-1:0]      load_store_addr_bus,
    output logic                             load_store_request_n,
    output logic                             load_store_sequential,
    output logic                             load_store_write,
    input  wire logic [cmts_pkg::DATA_W-1:0] memReadData,
    output logic [cmts_pkg::DATA_W-1:0]      memWriteData,
    output logic                             cpLoadValid,
    input  wire logic                        cpLoadReady,
    output logic [cmts_pkg::DATA_W-1:0]      cpLoadData,
    input  wire logic                        cpStoreValid,
    output logic                             cpStoreReady,
    input  wire logic [cmts_pkg::DATA_W-1:0] cpStoreData
);
    // ========================================================================
    // Sequencer state
    // ========================================================================
    cmts_pkg::cmts_state_t       state_r, state_nxt;
    logic                        isStore_r, isStore_nxt;
    logic                        firstAcc_r, firstAcc_nxt;
    logic [cmts_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [cmts_pkg::ADDR_W-1:0] pc_r, pc_nxt;
    logic                        rdPend_r, rdPend_nxt;
    logic                        access;
    logic                        lastAcc;
    logic                        accept;
    cmts_pkg::cmts_hs_t          hs;

    cmts_stream_if ldIn ();
    cmts_stream_if ldOut ();
    cmts_stream_if stIn ();
    cmts_stream_if stOut ();

    function automatic logic hsStarts(input cmts_pkg::cmts_hs_t h);
        hsStarts = (h == cmts_pkg::HS_GO) || (h == cmts_pkg::HS_LAST);
    endfunction

    // Transfers are refused outside the full-width state and when no coprocessor answers.
    assign accept = instrValid && fullWidthState && (coproc_load_op || coproc_store_op)
                    && (decode_stage_handshake != cmts_pkg::HS_NO_COPROC_CODE);
    // The decode-stage answer steers the idle cycle; the execute-stage answer steers
    // every cycle after it.
    assign hs     = (state_r == cmts_pkg::ST_IDLE) ? decode_stage_handshake : execute_stage_handshake;

    // ========================================================================
    // Transfer state machine
    // ========================================================================
    always_comb begin
        state_nxt    = state_r;
        isStore_nxt  = isStore_r;
        firstAcc_nxt = firstAcc_r;
        addr_nxt     = addr_r;
        pc_nxt       = pc_r;
        access       = 1'b0;
        lastAcc      = 1'b0;
        case (state_r)
            cmts_pkg::ST_IDLE: begin
                if (accept) begin
                    isStore_nxt  = coproc_store_op;
                    firstAcc_nxt = 1'b1;
                    addr_nxt     = startAddr;
                    pc_nxt       = pcAddr + cmts_pkg::FETCH_AHEAD;
                    if (decode_stage_handshake == cmts_pkg::HS_WAIT) begin
                        state_nxt = cmts_pkg::ST_WAIT;
                    end else if (decode_stage_handshake == cmts_pkg::HS_LAST) begin
                        state_nxt = cmts_pkg::ST_DONE;
                    end else begin
                        state_nxt = cmts_pkg::ST_XFER;
                    end
                end
            end
            cmts_pkg::ST_WAIT: begin
                // Only a transfer still waiting may be abandoned; once GO or LAST is seen
                // it runs to the end, so no memory access is ever cut short.
                if (hsStarts(hs)) begin
                    state_nxt = (hs == cmts_pkg::HS_LAST) ? cmts_pkg::ST_DONE : cmts_pkg::ST_XFER;
                end else if (irqPending) begin
                    state_nxt = cmts_pkg::ST_IDLE;
                end
            end
            cmts_pkg::ST_XFER: begin
                access       = 1'b1;
                firstAcc_nxt = 1'b0;
                addr_nxt     = addr_r + cmts_pkg::WORD_STEP;
                if (hs == cmts_pkg::HS_LAST) begin
                    state_nxt = cmts_pkg::ST_DONE;
                end
            end
            default: begin
                access    = 1'b1;
                lastAcc   = 1'b1;
                state_nxt = cmts_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r    <= cmts_pkg::ST_IDLE;
            isStore_r  <= 1'b0;
            firstAcc_r <= 1'b0;
            addr_r     <= cmts_pkg::ADDR_RESET;
            pc_r       <= cmts_pkg::ADDR_RESET;
        end else begin
            state_r    <= state_nxt;
            isStore_r  <= isStore_nxt;
            firstAcc_r <= firstAcc_nxt;
            addr_r     <= addr_nxt;
            pc_r       <= pc_nxt;
        end
    end

    // ========================================================================
    // Memory request outputs
    // ========================================================================
    // The fetch side stays idle for the whole transfer and resumes with a sequential
    // fetch in the last access cycle.
    assign load_store_addr_bus   = access ? addr_r : cmts_pkg::ADDR_RESET;
    assign load_store_request_n  = ~access;
    assign load_store_sequential = access && !firstAcc_r;
    assign load_store_write      = access && isStore_r;
    assign fetch_addr_bus        = pc_r;
    assign fetch_request_n       = !(lastAcc || (state_r == cmts_pkg::ST_IDLE));
    assign fetch_sequential      = lastAcc;
    assign condPass              = (state_r != cmts_pkg::ST_IDLE);
    assign cancel_after_issue    = 1'b0;
    assign instrAccept           = accept && (state_r == cmts_pkg::ST_IDLE);
    assign xferDone              = lastAcc;
    assign xferAbandoned         = (state_r == cmts_pkg::ST_WAIT) && !hsStarts(hs) && irqPending;
    assign noCoproc              = instrValid && (state_r == cmts_pkg::ST_IDLE)
                                   && (decode_stage_handshake == cmts_pkg::HS_NO_COPROC_CODE);

    // ========================================================================
    // Load path: read word returns one cycle after its address
    // ========================================================================
    always_comb begin
        rdPend_nxt = access && !isStore_r;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdPend_r <= 1'b0;
        end else begin
            rdPend_r <= rdPend_nxt;
        end
    end

    // Two entries absorb a short coprocessor stall; a longer one drops words, which
    // the coprocessor must not allow.
    assign ldIn.valid  = rdPend_r;
    assign ldIn.data   = memReadData;
    assign cpLoadValid = ldOut.valid;
    assign cpLoadData  = ldOut.data;
    assign ldOut.ready = cpLoadReady;

    cmts_skid_buf u_load_buf (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .inS     (ldIn),
        .outS    (ldOut)
    );

    // ========================================================================
    // Store path: the write word follows its address by one cycle
    // ========================================================================
    logic [cmts_pkg::DATA_W-1:0] wrData_r, wrData_nxt;

    // The store buffer must already hold a word when its address goes out; an empty
    // buffer writes a stale word.
    assign stIn.valid   = cpStoreValid;
    assign stIn.data    = cpStoreData;
    assign cpStoreReady = stIn.ready;
    assign stOut.ready  = access && isStore_r;

    always_comb begin
        wrData_nxt = wrData_r;
        if (access && isStore_r) begin
            wrData_nxt = stOut.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrData_r <= cmts_pkg::DATA_RESET;
        end else begin
            wrData_r <= wrData_nxt;
        end
    end

    assign memWriteData = wrData_r;

    cmts_skid_buf u_store_buf (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .inS     (stIn),
        .outS    (stOut)
    );

    // ========================================================================
    // Checks
    // ========================================================================
    // All checks are quiet while reset is held.
    seq_addr_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && $past(access) && !firstAcc_r) |-> (load_store_addr_bus == $past(load_store_addr_bus) + 32'h4))
        else $error("Sequential address did not step by four.");

    first_nonseq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && !$past(access)) |-> !load_store_sequential)
        else $error("First access was sequential.");

    wait_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_r == cmts_pkg::ST_WAIT) |-> (load_store_request_n && fetch_request_n))
        else $error("Request made while waiting.");

    go_starts_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((state_r == cmts_pkg::ST_WAIT) && hsStarts(execute_stage_handshake)) |=> !load_store_request_n)
        else $error("Access did not follow GO or LAST.");

    single_word_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (instrAccept && decode_stage_handshake == cmts_pkg::HS_LAST) |=> (xferDone ##1 load_store_request_n))
        else $error("Single word transfer not one cycle.");

    fetch_last_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && !fetch_request_n) |-> (fetch_sequential && xferDone))
        else $error("Fetch issued before the last cycle.");

    pass_cancel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        access |-> (condPass && !cancel_after_issue))
        else $error("Pass or cancel wrong during transfer.");

    full_width_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        instrAccept |-> fullWidthState)
        else $error("Transfer started outside full-width state.");

    read_return_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && !isStore_r) |=> ldIn.valid)
        else $error("Read word not captured next cycle.");

    done_to_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        xferDone |=> (state_r == cmts_pkg::ST_IDLE))
        else $error("No idle cycle after the last access.");

    last_ends_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((state_r == cmts_pkg::ST_XFER) && (execute_stage_handshake == cmts_pkg::HS_LAST)) |=> xferDone)
        else $error("LAST did not lead to the final access.");

    no_addr_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        load_store_request_n |-> (load_store_addr_bus == cmts_pkg::ADDR_RESET))
        else $error("Data address shown without a request.");

    write_word_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && isStore_r) |=> (memWriteData == $past(stOut.data)))
        else $error("Write word did not follow its address.");

    store_no_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && isStore_r) |=> !ldIn.valid)
        else $error("Store access captured a read word.");

    load_no_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && !isStore_r) |-> !load_store_write)
        else $error("Load access marked as a write.");

    abandon_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        xferAbandoned |=> ((state_r == cmts_pkg::ST_IDLE) && load_store_request_n))
        else $error("Abandoned transfer still running.");

    fetch_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((state_r != cmts_pkg::ST_IDLE) && $past(state_r != cmts_pkg::ST_IDLE)) |-> $stable(fetch_addr_bus))
        else $error("Fetch address moved during a transfer.");

    wait_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_r == cmts_pkg::ST_WAIT) |-> (condPass && !cancel_after_issue))
        else $error("Pass or cancel wrong while waiting.");

    refuse_no_coproc_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (decode_stage_handshake == cmts_pkg::HS_NO_COPROC_CODE) |-> !instrAccept)
        else $error("Instruction taken with no coprocessor.");
endmodule
`default_nettype wire

// ---- core/cmts_skid_buf.sv ----
// Two-entry word buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cmts_skid_buf (
    input  wire logic   ref_clk,
    input  wire logic   rst_n,
    cmts_stream_if.snk  inS,
    cmts_stream_if.src  outS
);
    logic [cmts_pkg::DATA_W-1:0] mem_r [cmts_pkg::BUF_DEPTH];
    logic [cmts_pkg::DATA_W-1:0] mem_nxt [cmts_pkg::BUF_DEPTH];
    logic                        wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [1:0]                  count_r, count_nxt;
    logic                        push, pop;

    assign inS.ready  = (count_r != 2'h2);
    assign outS.valid = (count_r != 2'h0);
    assign outS.data  = mem_r[rdPtr_r];
    assign push       = inS.valid && inS.ready;
    assign pop        = outS.valid && outS.ready;

    always_comb begin
        mem_nxt   = mem_r;
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        if (push) begin
            mem_nxt[wrPtr_r] = inS.data;
            wrPtr_nxt        = ~wrPtr_r;
        end
        if (pop) begin
            rdPtr_nxt = ~rdPtr_r;
        end
        count_nxt = count_r + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < cmts_pkg::BUF_DEPTH; i++) begin
                mem_r[i] <= cmts_pkg::DATA_RESET;
            end
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            mem_r   <= mem_nxt;
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    no_overflow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        count_r <= 2'h2) else $error("Buffer count above two.");
endmodule
`default_nettype wire

// ---- core/cmts_stream_if.sv ----
// Valid/ready word channel used between the sequencer and its buffers.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface cmts_stream_if;
    logic                      valid;
    logic                      ready;
    logic [cmts_pkg::DATA_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- testbench/cmts_cop_model.sv ----
// Far-side model: coprocessor handshakes, data memory and coprocessor word streams.
// Assumes the sequencer makes at most one data access a cycle once committed.
`timescale 1ns/1ps
`default_nettype none
module cmts_cop_model (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              instrAccept,
    input  wire logic              xferEnd,
    input  wire logic [2:0]        words,
    input  wire logic [2:0]        waits,
    input  wire logic              no_coproc_code,
    input  wire logic              loadStall,
    input  wire logic [31:0]       load_store_addr_bus,
    input  wire logic              load_store_request_n,
    input  wire logic              load_store_write,
    input  wire logic              cpStoreReady,
    output var cmts_pkg::cmts_hs_t decode_stage_handshake,
    output var cmts_pkg::cmts_hs_t execute_stage_handshake,
    output logic [31:0]            memReadData,
    output logic                   cpLoadReady,
    output logic                   cpStoreValid,
    output logic [31:0]            cpStoreData
);
    logic [3:0]         k_r;
    logic               act_r;
    int                 j;
    cmts_pkg::cmts_hs_t fst;
    // ============
    // Handshake answers, counted from the accepting cycle.
    always_comb begin
        j = int'(k_r) - int'(waits);
        fst = (words == 3'h1) ? cmts_pkg::HS_LAST : cmts_pkg::HS_GO;
        decode_stage_handshake = (waits != 3'h0) ? cmts_pkg::HS_WAIT : fst;
        if (no_coproc_code)
            decode_stage_handshake = cmts_pkg::HS_NO_COPROC_CODE;
        execute_stage_handshake = cmts_pkg::HS_NO_COPROC_CODE;
        if (act_r) begin
            if (j < 0)
                execute_stage_handshake = cmts_pkg::HS_WAIT;
            else if (j == 0)
                execute_stage_handshake = fst;
            else if (j < int'(words) - 1)
                execute_stage_handshake = cmts_pkg::HS_GO;
            else if (j == int'(words) - 1)
                execute_stage_handshake = cmts_pkg::HS_LAST;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            act_r <= 1'b0;
            k_r <= 4'h0;
        end else if (instrAccept) begin
            act_r <= 1'b1;
            k_r <= 4'h1;
        end else if (xferEnd) begin
            act_r <= 1'b0;
        end else if (act_r) begin
            k_r <= k_r + 4'h1;
        end
    end
    // Read word follows its address; otherwise the bus toggles so stale data never matches.
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            memReadData <= 32'h0;
        else if (!load_store_request_n && !load_store_write)
            memReadData <= load_store_addr_bus ^ 32'h5a5a_0000;
        else
            memReadData <= ~memReadData;
    end
    // Store words stay queued ahead so each write address finds its word.
    assign cpStoreValid = 1'b1;
    assign cpLoadReady = !loadStall;
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            cpStoreData <= 32'hc0de_0000;
        else if (cpStoreReady)
            cpStoreData <= cpStoreData + 32'h1;
    end
endmodule
`default_nettype wire

// ---- testbench/coproc_mem_transfer_sequencer_tb.sv ----
// Self-checking bench for the coprocessor memory transfer sequencer.
// Assumes cmts_cop_model stands in for the coprocessor and the data memory.
`timescale 1ns/1ps
`default_nettype none
module coproc_mem_transfer_sequencer_tb;
    typedef struct packed {logic [31:0] a; logic s; logic w;} cmts_acc_t;
    logic ref_clk, rst_n, instrValid, coproc_load_op, coproc_store_op, fullWidthState, irqPending;
    logic instrAccept, xferDone, xferAbandoned, noCoproc, condPass, cancel_after_issue, lsReq, inXfer;
    logic fetch_request_n, fetch_sequential, load_store_request_n, load_store_sequential, load_store_write;
    logic cpLoadValid, cpLoadReady, cpStoreValid, cpStoreReady, no_coproc_code, loadStall, prevWr;
    logic [31:0] startAddr, pcAddr, fetch_addr_bus, load_store_addr_bus, memReadData, memWriteData;
    logic [31:0] cpLoadData, cpStoreData, pcExp, stIdx, ldQ[$], stQ[$];
    logic [15:0] seed;
    logic [2:0]  words, waits;
    cmts_pkg::cmts_hs_t decode_stage_handshake, execute_stage_handshake;
    cmts_acc_t   accQ[$], e;
    int          err_count, samples_checked;
    assign lsReq = !load_store_request_n;
    cmts_sequencer cmts_sequencer_inst (.ref_clk, .rst_n, .instrValid, .coproc_load_op, .coproc_store_op,
        .fullWidthState, .startAddr, .pcAddr, .irqPending, .instrAccept, .xferDone, .xferAbandoned, .noCoproc,
        .decode_stage_handshake, .execute_stage_handshake, .condPass, .cancel_after_issue, .fetch_addr_bus,
        .fetch_request_n, .fetch_sequential, .load_store_addr_bus, .load_store_request_n,
        .load_store_sequential, .load_store_write, .memReadData, .memWriteData, .cpLoadValid, .cpLoadReady,
        .cpLoadData, .cpStoreValid, .cpStoreReady, .cpStoreData);
    cmts_cop_model cmts_cop_model_inst (.ref_clk, .rst_n, .instrAccept, .xferEnd(xferDone | xferAbandoned),
        .words, .waits, .no_coproc_code, .loadStall, .load_store_addr_bus, .load_store_request_n, .load_store_write,
        .cpStoreReady, .decode_stage_handshake, .execute_stage_handshake, .memReadData, .cpLoadReady,
        .cpStoreValid, .cpStoreData);
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ============
    // Shared tasks.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return instrAccept;
            1: return lsReq;
            2: return xferDone;
            default: return xferAbandoned;
        endcase
    endfunction
    task automatic waitHi(input int sel, input int lim, output int t);
        t = 0;
        while (pick(sel) !== 1'b1) begin
            @(negedge ref_clk);
            t++;
            if (t > lim) begin
                err_count++;
                $display("CHECK FAILED t=%0t wait ran out", $time);
                wrap_up();
            end
        end
    endtask
    // Runs one transfer of m words after n wait answers; ab abandons it by interrupt.
    task automatic xfer(input logic st, input int m, input int n, input logic ab);
        logic [31:0] a;
        int          t;
        seed = lfsr(seed);
        a = {14'h0, seed, 2'b00};
        pcExp = {seed, 16'h0100} + 32'h0000_000c;
        for (int i = 0; i < m && !ab; i++) begin
            accQ.push_back({a + 32'(4 * i), i > 0, st});
            if (st) begin
                stQ.push_back(32'hc0de_0000 + stIdx);
                stIdx = stIdx + 32'h1;
            end else begin
                ldQ.push_back((a + 32'(4 * i)) ^ 32'h5a5a_0000);
            end
        end
        instrValid <= 1'b1;
        coproc_store_op <= st;
        coproc_load_op <= !st;
        startAddr <= a;
        pcAddr <= {seed, 16'h0100};
        words <= 3'(m);
        waits <= 3'(n);
        waitHi(0, 20, t);
        @(posedge ref_clk);
        instrValid <= 1'b0;
        irqPending <= ab;
        inXfer = !ab;
        if (ab) begin
            waitHi(3, 20, t);
            chk(t === 1, "abandon cycle");
        end else begin
            waitHi(1, 20, t);
            chk(t === n + 1, "first access cycle");
            waitHi(2, 20, t);
            chk(t === m - 1, "transfer length");
        end
        @(posedge ref_clk);
        irqPending <= 1'b0;
        inXfer = 1'b0;
    endtask
    // ============
    // Monitor: takes the oldest noted result whenever one appears.
    always @(negedge ref_clk) begin
        if (rst_n) begin
            if (prevWr)
                chk(stQ.size() > 0 && memWriteData === stQ.pop_front(), "store word");
            prevWr = !load_store_request_n && load_store_write;
            if (lsReq === 1'b1) begin
                e = (accQ.size() > 0) ? accQ.pop_front() : '1;
                chk({load_store_addr_bus, load_store_sequential, load_store_write} === e, "access");
            end
            if (cpLoadValid === 1'b1 && cpLoadReady === 1'b1)
                chk(ldQ.size() > 0 && cpLoadData === ldQ.pop_front(), "load word");
            chk(cancel_after_issue === 1'b0, "cancel");
            if (inXfer && xferAbandoned !== 1'b1) begin
                chk(condPass === 1'b1, "pass");
                chk(fetch_addr_bus === pcExp && fetch_request_n === !xferDone
                    && fetch_sequential === xferDone, "fetch side");
            end
        end
    end
    // ============
    // Main sequence.
    initial begin
        {rst_n, instrValid, coproc_load_op, coproc_store_op, fullWidthState, irqPending} = '0;
        {no_coproc_code, loadStall, inXfer, prevWr} = '0;
        {startAddr, pcAddr, stIdx} = '0;
        words = 3'h1;
        waits = 3'h0;
        seed = 16'h1e00;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        fullWidthState <= 1'b1;
        @(posedge ref_clk);
        xfer(1'b0, 1, 0, 1'b0);
        xfer(1'b1, 1, 2, 1'b0);
        xfer(1'b1, 4, 0, 1'b0);
        for (int r = 0; r < 12; r++)
            xfer(seed[0], int'(seed[2:1]) + 1, int'(seed[4:3]), 1'b0);
        xfer(1'b0, 2, 5, 1'b1);
        loadStall <= 1'b1;
        xfer(1'b0, 2, 1, 1'b0);
        repeat (3) @(posedge ref_clk);
        loadStall <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(ldQ.size() == 0 && stQ.size() == 0 && cpStoreReady === 1'b0, "leftovers");
        @(posedge ref_clk);
        fullWidthState <= 1'b0;
        instrValid <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(instrAccept === 1'b0, "compressed state refused");
        @(posedge ref_clk);
        fullWidthState <= 1'b1;
        no_coproc_code <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(instrAccept === 1'b0 && noCoproc === 1'b1, "no coprocessor");
        @(posedge ref_clk);
        instrValid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        wrap_up();
    end
endmodule
`default_nettype wire
